// ==== rtl/bide_map.svh ====
// Constants for the branch and increment/decrement execute block.
// Assumes one instruction word is offered per enabled clock edge.
//
// What this block does
// - Jump loads immediate into counter bits 10:0
// - Jump fills counter bits 12:11 from latch
// - Jump always takes two instruction cycles
// - Decrement subtracts one, routed by destination
// - Destination zero writes accumulator, register kept
// - Destination one writes back into register
// - Plain inc/dec update zero flag only
// - Decrement-skip on zero replaces next with no-op
// - Increment-skip on zero replaces next with no-op
// - Nonzero skip result runs next instruction normally
// - Skip variants leave every status flag alone
`ifndef BIDE_MAP_SVH
`define BIDE_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BIDE_INSTR_W 14
`define BIDE_DATA_W 8
`define BIDE_ADDR_W 7
`define BIDE_PC_W 13
`define BIDE_K_W 11
`define BIDE_LATCH_W 5
`define BIDE_MEM_DEPTH 128

// ----------------------------------------------------------------
// Field positions in the instruction word, page latch and program counter
// ----------------------------------------------------------------
`define BIDE_OP_HI 13
`define BIDE_OP_LO 8
`define BIDE_JOP_HI 13
`define BIDE_JOP_LO 11
`define BIDE_DEST_BIT 7
`define BIDE_FADDR_HI 6
`define BIDE_FADDR_LO 0
`define BIDE_K_HI 10
`define BIDE_K_LO 0
`define BIDE_LATCH_HI 4
`define BIDE_LATCH_LO 3
`define BIDE_PC_K_HI 10
`define BIDE_PC_UP_HI 12
`define BIDE_PC_UP_LO 11

// ----------------------------------------------------------------
// Opcode values
// ----------------------------------------------------------------
`define BIDE_OP_JUMP 3'h7
`define BIDE_OP_DEC 6'h01
`define BIDE_OP_INC 6'h02
`define BIDE_OP_DEC_SKIP 6'h03
`define BIDE_OP_INC_SKIP 6'h04

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define BIDE_PC_RST 13'h0000
`define BIDE_PC_STEP 13'h0001
`define BIDE_DATA_RST 8'h00
`define BIDE_DATA_ONE 8'h01
`define BIDE_DATA_ZERO 8'h00

`endif

// ==== rtl/bide_pkg.sv ====
// Types for the branch and increment/decrement execute block.
// Assumes bide_map.svh is on the include path.
`include "bide_map.svh"

package bide_pkg;

  // ----------------------------------------------------------------
  // Decoded operation
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BIDE_KIND_NONE = 3'h0,
    BIDE_KIND_JUMP = 3'h1,
    BIDE_KIND_DEC = 3'h2,
    BIDE_KIND_INC = 3'h3,
    BIDE_KIND_DEC_SKIP = 3'h4,
    BIDE_KIND_INC_SKIP = 3'h5
  } bide_kind_type;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic {
    BIDE_ST_EXEC = 1'b0,
    BIDE_ST_FLUSH = 1'b1
  } bide_state_type;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  typedef struct packed {
    bide_kind_type kind;
    logic dest;
    logic [`BIDE_ADDR_W-1:0] faddr;
    logic [`BIDE_K_W-1:0] k;
  } bide_decoded_type;

  // ----------------------------------------------------------------
  // Arithmetic result
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`BIDE_DATA_W-1:0] value;
    logic zero;
  } bide_result_type;

endpackage : bide_pkg

// ==== rtl/bide_step.sv ====
// Increment or decrement of one data byte, with zero detect.
// Assumes a purely combinational use from the same clock domain.
`timescale 1ns/100ps
`include "bide_map.svh"

module bide_step
  import bide_pkg::*;
(
  input wire logic [`BIDE_DATA_W-1:0] operand_i,
  input wire logic down_i,
  output bide_result_type result_o
);

  // ----------------------------------------------------------------
  // Wrapping add or subtract
  // ----------------------------------------------------------------
  logic [`BIDE_DATA_W-1:0] sum;

  always_comb begin
    if (down_i) begin
      sum = operand_i - `BIDE_DATA_ONE;
    end else begin
      sum = operand_i + `BIDE_DATA_ONE;
    end
  end

  assign result_o = {sum, (sum == `BIDE_DATA_ZERO)};

endmodule : bide_step

// ==== rtl/bide_exec.sv ====
// Execute stage for jump and increment/decrement with optional skip.
// Assumes instructions and the page latch come from logic on mclk_i.
`timescale 1ns/100ps
`include "bide_map.svh"

module bide_exec
  import bide_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [`BIDE_INSTR_W-1:0] instr_i,
  input wire logic [`BIDE_LATCH_W-1:0] pc_high_latch_i,
  input wire logic load_en_i,
  input wire logic [`BIDE_ADDR_W-1:0] load_addr_i,
  input wire logic [`BIDE_DATA_W-1:0] load_data_i,
  input wire logic [`BIDE_ADDR_W-1:0] peek_addr_i,
  output logic [`BIDE_PC_W-1:0] program_counter_o,
  output logic [`BIDE_DATA_W-1:0] accum_o,
  output logic zero_flag_o,
  output logic flush_o,
  output logic executed_o,
  output logic discarded_o,
  output logic [`BIDE_DATA_W-1:0] peek_data_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bide_state_type state;
  bide_state_type next_state;
  logic [`BIDE_DATA_W-1:0] mem [`BIDE_MEM_DEPTH];
  logic [`BIDE_PC_W-1:0] program_counter;
  logic [`BIDE_DATA_W-1:0] accum;
  logic zero_flag;
  logic executed;
  logic discarded;
  logic [`BIDE_DATA_W-1:0] peek_data;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  bide_decoded_type dec;
  logic [`BIDE_OP_HI-`BIDE_OP_LO:0] opcode;

  assign opcode = instr_i[`BIDE_OP_HI:`BIDE_OP_LO];

  always_comb begin
    dec.dest = instr_i[`BIDE_DEST_BIT];
    dec.faddr = instr_i[`BIDE_FADDR_HI:`BIDE_FADDR_LO];
    dec.k = instr_i[`BIDE_K_HI:`BIDE_K_LO];
    dec.kind = BIDE_KIND_NONE;
    if (instr_i[`BIDE_JOP_HI:`BIDE_JOP_LO] == `BIDE_OP_JUMP) begin
      dec.kind = BIDE_KIND_JUMP;
    end else if (opcode == `BIDE_OP_DEC) begin
      dec.kind = BIDE_KIND_DEC;
    end else if (opcode == `BIDE_OP_INC) begin
      dec.kind = BIDE_KIND_INC;
    end else if (opcode == `BIDE_OP_DEC_SKIP) begin
      dec.kind = BIDE_KIND_DEC_SKIP;
    end else if (opcode == `BIDE_OP_INC_SKIP) begin
      dec.kind = BIDE_KIND_INC_SKIP;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic [`BIDE_DATA_W-1:0] operand;
  logic step_down;
  bide_result_type result;

  assign operand = mem[dec.faddr];
  assign step_down = (dec.kind == BIDE_KIND_DEC) ||
                     (dec.kind == BIDE_KIND_DEC_SKIP);

  bide_step u_step (
    .operand_i(operand),
    .down_i(step_down),
    .result_o(result)
  );

  // ----------------------------------------------------------------
  // Qualified events
  // ----------------------------------------------------------------
  logic take;
  logic run;
  logic is_step;
  logic is_plain;
  logic is_skip;
  logic is_jump;
  logic skip_taken;
  logic write_reg;
  logic write_acc;

  assign take = ce_i && instr_valid_i;
  assign run = take && (state == BIDE_ST_EXEC);
  assign is_jump = (dec.kind == BIDE_KIND_JUMP);
  assign is_plain = (dec.kind == BIDE_KIND_DEC) ||
                    (dec.kind == BIDE_KIND_INC);
  assign is_skip = (dec.kind == BIDE_KIND_DEC_SKIP) ||
                   (dec.kind == BIDE_KIND_INC_SKIP);
  assign is_step = is_plain || is_skip;
  assign skip_taken = run && is_skip && result.zero;
  assign write_reg = run && is_step && dec.dest;
  assign write_acc = run && is_step && !dec.dest;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      BIDE_ST_EXEC: begin
        if (run && is_jump) begin
          next_state = BIDE_ST_FLUSH;
        end else if (skip_taken) begin
          next_state = BIDE_ST_FLUSH;
        end else begin
          next_state = BIDE_ST_EXEC;
        end
      end
      BIDE_ST_FLUSH: begin
        if (take) begin
          next_state = BIDE_ST_EXEC;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= BIDE_ST_EXEC;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Registered copy of the flush state for the output
  logic flush;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flush <= 1'b0;
    end else if (ce_i) begin
      flush <= (next_state == BIDE_ST_FLUSH);
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      program_counter <= `BIDE_PC_RST;
    end else if (run && is_jump) begin
      program_counter[`BIDE_PC_K_HI:0] <= dec.k;
      program_counter[`BIDE_PC_UP_HI:`BIDE_PC_UP_LO] <=
        pc_high_latch_i[`BIDE_LATCH_HI:`BIDE_LATCH_LO];
    end else if (take) begin
      program_counter <= program_counter + `BIDE_PC_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      accum <= `BIDE_DATA_RST;
    end else if (write_acc) begin
      accum <= result.value;
    end
  end

  // ----------------------------------------------------------------
  // Zero flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      zero_flag <= 1'b0;
    end else if (run && is_plain) begin
      zero_flag <= result.zero;
    end
  end
  // Skip variants never reach the flag update above.

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `BIDE_MEM_DEPTH; i++) begin
        mem[i] <= `BIDE_DATA_RST;
      end
    end else if (write_reg) begin
      mem[dec.faddr] <= result.value;
    end else if (ce_i && load_en_i) begin
      mem[load_addr_i] <= load_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Per-cycle reports
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      executed <= 1'b0;
      discarded <= 1'b0;
    end else if (ce_i) begin
      executed <= run;
      discarded <= take && (state == BIDE_ST_FLUSH);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      peek_data <= `BIDE_DATA_RST;
    end else if (ce_i) begin
      peek_data <= mem[peek_addr_i];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign program_counter_o = program_counter;
  assign accum_o = accum;
  assign zero_flag_o = zero_flag;
  assign flush_o = flush;
  assign executed_o = executed;
  assign discarded_o = discarded;
  assign peek_data_o = peek_data;

endmodule : bide_exec

// ==== sim/bide_exec_sva.sv ====
// Port assertions for the execute block.
// Assumes one clock and the map header on the include path.
`timescale 1ns/100ps
`include "bide_map.svh"

module bide_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [`BIDE_INSTR_W-1:0] instr_i,
  input wire logic [`BIDE_LATCH_W-1:0] pc_high_latch_i,
  input wire logic [`BIDE_PC_W-1:0] program_counter_o,
  input wire logic [`BIDE_DATA_W-1:0] accum_o,
  input wire logic zero_flag_o,
  input wire logic flush_o,
  input wire logic discarded_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------
  // Decode
  // ------------------------------------------------
  logic go, jmp, plain, skip;
  logic [5:0] op;
  assign op = instr_i[13:8];
  assign go = ce_i && instr_valid_i && !flush_o;
  assign jmp = go && instr_i[13:11] == `BIDE_OP_JUMP;
  assign plain = go && (op == `BIDE_OP_DEC || op == `BIDE_OP_INC);
  assign skip = go && (op == `BIDE_OP_DEC_SKIP || op == `BIDE_OP_INC_SKIP);
  sequence s_jump;
    jmp;
  endsequence
  sequence s_drop;
    ce_i && instr_valid_i && flush_o;
  endsequence
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  a_jump_low_bits: assert property (
    s_jump |=> program_counter_o[10:0] == $past(instr_i[10:0]))
    else $error("jump low bits wrong");
  a_jump_page_bits: assert property (
    s_jump |=> program_counter_o[12:11] == $past(pc_high_latch_i[4:3]))
    else $error("jump page bits wrong");
  a_jump_two_cycles: assert property (
    s_jump |=> flush_o && !discarded_o)
    else $error("jump not two cycles");
  a_jump_drop_next: assert property (
    s_jump ##1 s_drop |=> discarded_o && !flush_o)
    else $error("word after jump not dropped");
  a_dest_keeps_accum: assert property (
    (plain || skip) && instr_i[7] |=> $stable(accum_o))
    else $error("accumulator written");
  a_plain_zero_flag: assert property (
    plain && !instr_i[7] |=> zero_flag_o == (accum_o == 8'h00))
    else $error("zero flag wrong");
  a_skip_keeps_flag: assert property (
    skip |=> $stable(zero_flag_o))
    else $error("skip changed flag");
  a_skip_on_zero: assert property (
    skip && !instr_i[7] |=> flush_o == (accum_o == 8'h00))
    else $error("skip decision wrong");
  a_drop_once: assert property (
    s_drop |=> !flush_o && discarded_o)
    else $error("discard wrong");
  a_pc_step: assert property (
    go && !jmp |=> program_counter_o == $past(program_counter_o) + 13'h1)
    else $error("counter step wrong");
endmodule : bide_chk

bind bide_exec bide_chk u_chk (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .ce_i(ce_i),
  .instr_valid_i(instr_valid_i),
  .instr_i(instr_i),
  .pc_high_latch_i(pc_high_latch_i),
  .program_counter_o(program_counter_o),
  .accum_o(accum_o),
  .zero_flag_o(zero_flag_o),
  .flush_o(flush_o),
  .discarded_o(discarded_o)
);

// ==== sim/testbench.sv ====
// Random instruction mix checked against a bench model.
// Assumes design files and checker compiled first.
`timescale 1ns/100ps

module testbench;
  logic mclk_i = 0, rst_n_i = 0, ce_i = 1, instr_valid_i = 0, load_en_i = 0;
  logic [13:0] instr_i = '0;
  logic [4:0] pc_high_latch_i = '0;
  logic [6:0] load_addr_i = '0, peek_addr_i = '0;
  logic [7:0] load_data_i = '0, accum_o, peek_data_o, acc, pk, r, v;
  logic [12:0] program_counter_o, pc;
  logic zero_flag_o, flush_o, executed_o, discarded_o;
  logic z, fl, ex, ds, wr;
  logic [7:0] mem [128];
  logic [31:0] seed = 32'd4104;
  logic [5:0] op;
  logic [2:0] a;
  int miscompares = 0, n_tests = 0, cyc, s;

  initial forever #4 mclk_i = ~mclk_i;

  bide_exec u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .pc_high_latch_i(pc_high_latch_i), .load_en_i(load_en_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i),
    .peek_addr_i(peek_addr_i), .program_counter_o(program_counter_o),
    .accum_o(accum_o), .zero_flag_o(zero_flag_o), .flush_o(flush_o),
    .executed_o(executed_o), .discarded_o(discarded_o),
    .peek_data_o(peek_data_o));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string nm, input logic [12:0] sn,
                       input logic [12:0] ex_v);
    n_tests++;
    if (sn !== ex_v) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex_v, sn);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ------------------------------------------------
  // Stimulus and model
  // ------------------------------------------------
  initial begin
    for (cyc = 0; cyc < 3000; cyc++) begin
      @(negedge mclk_i);
      if (cyc > 0) begin
        check("pc", program_counter_o, pc);
        check("accum", 13'(accum_o), 13'(acc));
        check("zero", 13'(zero_flag_o), 13'(z));
        check("flush", 13'(flush_o), 13'(fl));
        check("exec", 13'(executed_o), 13'(ex));
        check("drop", 13'(discarded_o), 13'(ds));
        check("mem", 13'(peek_data_o), 13'(pk));
      end
      rst_n_i = !(cyc < 5 || (cyc >= 1500 && cyc < 1503));
      ce_i = !rst_n_i || rnd() % 16 != 0;
      instr_valid_i = rnd() % 8 != 0;
      load_en_i = rnd() % 4 == 0;
      a = 3'(rnd());
      load_addr_i = {{4{&a}}, a};
      v = 8'(rnd());
      load_data_i = v[2] ? v : {{7{v[1]}}, v[0] ^ v[1]};
      a = 3'(rnd());
      peek_addr_i = {{4{&a}}, a};
      pc_high_latch_i = 5'(rnd());
      s = rnd() % 8;
      a = 3'(rnd());
      op = s == 7 ? 6'h00 : 6'(s > 4 ? s - 2 : s);
      instr_i = s == 0 ? {3'h7, 11'(rnd())} : {op, rnd() % 2 == 1, {4{&a}}, a};
      if (!rst_n_i) begin
        pc = 0;
        acc = 0;
        z = 0;
        fl = 0;
        pk = 0;
        ex = 0;
        ds = 0;
        foreach (mem[i]) mem[i] = 0;
      end else if (ce_i) begin
        wr = 0;
        ex = 0;
        ds = 0;
        pk = mem[peek_addr_i];
        if (instr_valid_i && fl) begin
          pc++;
          fl = 0;
          ds = 1;
        end else if (instr_valid_i) begin
          ex = 1;
          pc++;
          op = instr_i[13:8];
          if (instr_i[13:11] == 3'h7) begin
            pc = {pc_high_latch_i[4:3], instr_i[10:0]};
            fl = 1;
          end else if (op inside {[1:4]}) begin
            r = mem[instr_i[6:0]] + (op[0] ? 8'hff : 8'h01);
            wr = instr_i[7];
            if (instr_i[7]) mem[instr_i[6:0]] = r;
            else acc = r;
            if (op < 3) z = r == 0;
            else fl = r == 0;
          end
        end
        // Core writeback wins over a preload in the same cycle
        if (load_en_i && !wr) mem[load_addr_i] = load_data_i;
      end
    end
    summarize();
  end
endmodule : testbench
